// *** pkg/adccal_defines.svh ***
// Offsets, field positions, reset values and timing counts of the calibration mode control.
// Assumes inclusion by bare name; holds definitions only.
`ifndef ADCCAL_DEFINES_SVH
`define ADCCAL_DEFINES_SVH

// Register word offsets (byte addresses)
`define ADCCAL_OFS_MODE 8'h00
`define ADCCAL_OFS_OFFSET_CAL 8'h04
`define ADCCAL_OFS_GAIN_CAL 8'h08
`define ADCCAL_OFS_STATUS 8'h0c
`define ADCCAL_OFS_IRQ_STAT 8'h10
`define ADCCAL_OFS_IRQ_MASK 8'h14
`define ADCCAL_OFS_CAL_INPUT 8'h18
`define ADCCAL_OFS_CODE_IN 8'h1c
`define ADCCAL_OFS_CODE_OUT 8'h20

// Mode word field positions
`define ADCCAL_MODE_HI 15
`define ADCCAL_MODE_LO 13
`define ADCCAL_POL_BIT 12
`define ADCCAL_DEN_BIT 11
`define ADCCAL_PHI_BIT 10
`define ADCCAL_PLO_BIT 9
`define ADCCAL_CH_HI 2
`define ADCCAL_CH_LO 0
`define ADCCAL_MODE_RST 16'h0174

// Interrupt status bits
`define ADCCAL_IRQ_ZERO_DONE 0
`define ADCCAL_IRQ_FULL_DONE 1
`define ADCCAL_IRQ_ABORT 2

// Calibration duration in microseconds and in clock cycles at 100 MHz
`define ADCCAL_CAL_TIME_US 10
`define ADCCAL_CLK_MHZ 100
`define ADCCAL_CAL_CYCLES (`ADCCAL_CAL_TIME_US * `ADCCAL_CLK_MHZ)

`endif

// *** pkg/adccal_pkg.sv ***
// Types of the calibration mode control.
// Assumes the defines header is compiled alongside.
package adccal_pkg;

	typedef enum logic [2:0] {
		adccal_mode_sync = 3'h0,
		adccal_mode_cont = 3'h1,
		adccal_mode_single = 3'h2,
		adccal_mode_standby = 3'h3,
		adccal_mode_zero_self = 3'h4,
		adccal_mode_full_self = 3'h5,
		adccal_mode_zero_sys = 3'h6,
		adccal_mode_full_sys = 3'h7
	} adccal_mode_type;

	// Gray along idle -> run -> finish; finish -> idle flips both bits
	typedef enum logic [1:0] {
		adccal_st_idle = 2'b00,
		adccal_st_run = 2'b01,
		adccal_st_done = 2'b11
	} adccal_state_type;

endpackage

// *** design/adccal_mode_ctrl.sv ***
// Calibration mode control of a sigma-delta converter: mode word, calibration sequencing,
// calibration result registers, output coding and the two shared digital port pins.
// Assumes a classic Wishbone master on clk_sys; calibration input sample comes from a register
// standing in for the modulator result, since the analog path lies outside this block.
// Operation
// RULE_01 - Mode 100 runs zero-scale self calibration on selected channel, shorted inputs.
// RULE_02 - Any finished zero-scale calibration loads the offset calibration register.
// RULE_03 - Mode 101 runs full-scale self calibration on internal full-scale signal.
// RULE_04 - Any finished full-scale calibration loads the gain calibration register.
// RULE_05 - Mode 110 runs zero-scale system calibration on the external input voltage.
// RULE_06 - Mode 111 runs full-scale system calibration on the external input voltage.
// RULE_07 - After any calibration return to sync idle, mode field cleared to 000.
// RULE_08 - Ready low output and status bit go high at start, low at completion.
// RULE_09 - Polarity 0 gives bipolar offset binary coding.
// RULE_10 - Polarity 1 gives unipolar straight binary coding.
// RULE_11 - Port enable 1 turns both shared input pins into driven digital outputs.
// RULE_12 - Any mode field write abandons current mode and starts the new one.
// RULE_13 - While enabled each shared pin holds its port bit level.
// RULE_14 - Calibration registers change only when a matching calibration completes.
//
// Decided for this implementation: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ns
`include "adccal_defines.svh"

module adccal_mode_ctrl #(
	parameter int CAL_CYCLES = `ADCCAL_CAL_CYCLES,
	parameter int DATA_W = 24
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Status
	output logic ready_n,
	output logic irq,
	output logic [2:0] cal_channel,
	output logic cal_internal_short,
	output logic cal_internal_full,
	// Shared port pins
	output logic shared_input3_port_pin_o,
	output logic shared_input3_port_pin_oe,
	output logic shared_input4_port_pin_o,
	output logic shared_input4_port_pin_oe
);

	localparam logic [15:0] CAL_LAST = 16'(CAL_CYCLES - 1);

	logic [15:0] mode_word;
	logic [DATA_W-1:0] offset_cal;
	logic [DATA_W-1:0] gain_cal;
	logic [DATA_W-1:0] cal_input;
	logic [DATA_W-1:0] code_in;
	logic [DATA_W-1:0] code_out;
	logic [2:0] irq_stat;
	logic [2:0] irq_mask;
	logic [15:0] cal_count;
	adccal_pkg::adccal_state_type state;
	adccal_pkg::adccal_mode_type cal_kind;

	logic wr_req;
	logic rd_req;
	logic mode_wr;
	logic zero_done;
	logic full_done;
	logic cal_abort;
	logic stat_rd;
	logic [2:0] next_mode;
	logic [31:0] next_dat;
	adccal_pkg::adccal_mode_type wr_mode;

	// One access per ack; ack drops the cycle after it is given
	assign wr_req = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
	assign rd_req = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
	assign mode_wr = wr_req && wb_adr_i == `ADCCAL_OFS_MODE && wb_sel_i[1];
	assign next_mode = wb_dat_i[`ADCCAL_MODE_HI:`ADCCAL_MODE_LO];
	assign wr_mode = adccal_pkg::adccal_mode_type'(next_mode);
	assign zero_done = state == adccal_pkg::adccal_st_done && !cal_kind[0];
	assign full_done = state == adccal_pkg::adccal_st_done && cal_kind[0];
	assign cal_abort = mode_wr && state == adccal_pkg::adccal_st_run;
	assign stat_rd = rd_req && wb_adr_i == `ADCCAL_OFS_IRQ_STAT;

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
		end
	end

	// Mode word; the mode field clears itself when a calibration ends
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			mode_word <= `ADCCAL_MODE_RST;
		end else begin
			if (wr_req && wb_adr_i == `ADCCAL_OFS_MODE) begin
				if (wb_sel_i[0]) begin
					mode_word[7:0] <= wb_dat_i[7:0];
				end
				if (wb_sel_i[1]) begin
					mode_word[15:8] <= wb_dat_i[15:8];
				end
			end
			// A low-byte-only write in the done cycle must not keep the mode alive
			if (state == adccal_pkg::adccal_st_done && !mode_wr) begin
				mode_word[`ADCCAL_MODE_HI:`ADCCAL_MODE_LO] <= 3'h0; // RULE_07
			end
		end
	end

	// Calibration sequencer; a mode write always restarts it
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			state <= adccal_pkg::adccal_st_idle;
			cal_kind <= adccal_pkg::adccal_mode_sync;
			cal_count <= 16'h0000;
		end else if (mode_wr) begin // RULE_12
			cal_count <= 16'h0000;
			cal_kind <= wr_mode;
			if (next_mode[2]) begin // RULE_01 RULE_03 RULE_05 RULE_06
				state <= adccal_pkg::adccal_st_run;
			end else begin
				state <= adccal_pkg::adccal_st_idle;
			end
		end else begin
			unique case (state)
				adccal_pkg::adccal_st_idle: begin
					cal_count <= 16'h0000;
				end
				adccal_pkg::adccal_st_run: begin
					if (cal_count == CAL_LAST) begin
						state <= adccal_pkg::adccal_st_done;
					end else begin
						cal_count <= cal_count + 16'h0001;
					end
				end
				adccal_pkg::adccal_st_done: begin
					state <= adccal_pkg::adccal_st_idle; // RULE_07
				end
				// Unused code after an upset falls back to idle
				default: begin
					state <= adccal_pkg::adccal_st_idle;
				end
			endcase
		end
	end

	// Analog front-end steering for the running calibration
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			cal_channel <= 3'h0;
			cal_internal_short <= 1'b0;
			cal_internal_full <= 1'b0;
		end else begin
			cal_channel <= mode_word[`ADCCAL_CH_HI:`ADCCAL_CH_LO];
			cal_internal_short <= state == adccal_pkg::adccal_st_run &&
				cal_kind == adccal_pkg::adccal_mode_zero_self; // RULE_01
			cal_internal_full <= state == adccal_pkg::adccal_st_run &&
				cal_kind == adccal_pkg::adccal_mode_full_self; // RULE_03
		end
	end

	// Results land only at the end of a matching calibration
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			offset_cal <= '0;
			gain_cal <= '0;
		end else begin
			if (zero_done) begin
				offset_cal <= cal_input; // RULE_02 RULE_14
			end
			if (full_done) begin
				gain_cal <= cal_input; // RULE_04 RULE_14
			end
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			cal_input <= '0;
			code_in <= '0;
		end else if (wr_req && wb_sel_i == 4'hf) begin
			if (wb_adr_i == `ADCCAL_OFS_CAL_INPUT) begin
				cal_input <= wb_dat_i[DATA_W-1:0];
			end
			if (wb_adr_i == `ADCCAL_OFS_CODE_IN) begin
				code_in <= wb_dat_i[DATA_W-1:0];
			end
		end
	end

	// Signed two's complement in; bipolar flips the sign bit, unipolar clamps negatives
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			code_out <= '0;
		end else if (!mode_word[`ADCCAL_POL_BIT]) begin
			code_out <= {~code_in[DATA_W-1], code_in[DATA_W-2:0]}; // RULE_09
		end else if (code_in[DATA_W-1]) begin
			code_out <= '0; // RULE_10
		end else begin
			code_out <= {code_in[DATA_W-2:0], 1'b0}; // RULE_10
		end
	end

	// Ready low is high while a calibration runs
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			ready_n <= 1'b0;
		end else begin
			ready_n <= mode_wr ? next_mode[2] : state == adccal_pkg::adccal_st_run; // RULE_08
		end
	end

	// Sticky events; a set in the cycle of a status read wins
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			irq_stat <= 3'h0;
			irq_mask <= 3'h0;
			irq <= 1'b0;
		end else begin
			irq_stat <= (stat_rd ? 3'h0 : irq_stat) |
				{cal_abort, full_done, zero_done};
			if (wr_req && wb_adr_i == `ADCCAL_OFS_IRQ_MASK && wb_sel_i[0]) begin
				irq_mask <= wb_dat_i[2:0];
			end
			irq <= |(irq_stat & irq_mask) && !stat_rd;
		end
	end

	// Shared pins driven only while the port enable is set
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			shared_input3_port_pin_o <= 1'b0;
			shared_input3_port_pin_oe <= 1'b0;
			shared_input4_port_pin_o <= 1'b0;
			shared_input4_port_pin_oe <= 1'b0;
		end else begin
			shared_input3_port_pin_oe <= mode_word[`ADCCAL_DEN_BIT]; // RULE_11
			shared_input4_port_pin_oe <= mode_word[`ADCCAL_DEN_BIT]; // RULE_11
			shared_input3_port_pin_o <= mode_word[`ADCCAL_DEN_BIT] & mode_word[`ADCCAL_PHI_BIT]; // RULE_13
			shared_input4_port_pin_o <= mode_word[`ADCCAL_DEN_BIT] & mode_word[`ADCCAL_PLO_BIT]; // RULE_13
		end
	end

	always_comb begin
		next_dat = 32'h0000_0000;
		unique case (wb_adr_i)
			`ADCCAL_OFS_MODE: next_dat = {16'h0000, mode_word};
			`ADCCAL_OFS_OFFSET_CAL: next_dat[DATA_W-1:0] = offset_cal;
			`ADCCAL_OFS_GAIN_CAL: next_dat[DATA_W-1:0] = gain_cal;
			`ADCCAL_OFS_STATUS: next_dat = {30'h0, state == adccal_pkg::adccal_st_run, ready_n}; // RULE_08
			`ADCCAL_OFS_IRQ_STAT: next_dat = {29'h0, irq_stat};
			`ADCCAL_OFS_IRQ_MASK: next_dat = {29'h0, irq_mask};
			`ADCCAL_OFS_CAL_INPUT: next_dat[DATA_W-1:0] = cal_input;
			`ADCCAL_OFS_CODE_IN: next_dat[DATA_W-1:0] = code_in;
			`ADCCAL_OFS_CODE_OUT: next_dat[DATA_W-1:0] = code_out;
			default: next_dat = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (rd_req) begin
			wb_dat_o <= next_dat;
		end
	end

	// Mode field, sequencing and calibration results
	a_cal_mode_clear: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_07
		state == adccal_pkg::adccal_st_done && !mode_wr |=> mode_word[15:13] == 3'h0)
		else $error("mode field not cleared after calibration");
	a_run_done: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_07
		state == adccal_pkg::adccal_st_run && cal_count == CAL_LAST && !mode_wr |=> state == adccal_pkg::adccal_st_done)
		else $error("calibration did not finish at its count");
	a_mode_idle: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_12
		mode_wr && !next_mode[2] |=> state == adccal_pkg::adccal_st_idle && !ready_n)
		else $error("non-calibration mode write left sequencer running");
	a_offset_load: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_02
		zero_done |=> offset_cal == $past(cal_input))
		else $error("offset register not loaded");
	a_gain_load: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_04
		full_done |=> gain_cal == $past(cal_input))
		else $error("gain register not loaded");
	a_cal_hold: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_14
		!zero_done && !full_done |=> $stable(offset_cal) && $stable(gain_cal))
		else $error("calibration register changed without calibration");

	// Ready output across a calibration
	a_ready_start: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_08 RULE_12
		mode_wr && next_mode[2] |=> ready_n && state == adccal_pkg::adccal_st_run)
		else $error("ready not high at calibration start");
	a_ready_end: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_08
		state == adccal_pkg::adccal_st_done && !mode_wr |=> !ready_n ##1 !ready_n || $past(mode_wr, 1))
		else $error("ready not low after calibration");

	// Front-end steering per calibration kind
	a_short_self: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_01
		state == adccal_pkg::adccal_st_run && cal_kind == adccal_pkg::adccal_mode_zero_self |=> cal_internal_short)
		else $error("inputs not shorted during zero self calibration");
	a_full_self: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_03 RULE_05 RULE_06
		state == adccal_pkg::adccal_st_run && cal_kind[1:0] != 2'b01 |=> !cal_internal_full)
		else $error("internal full scale used outside full self calibration");
	a_zero_sys_ext: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_05
		state == adccal_pkg::adccal_st_run && cal_kind == adccal_pkg::adccal_mode_zero_sys |=>
		!cal_internal_short && !cal_internal_full)
		else $error("system zero calibration not on external input");
	a_cal_channel: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_01 RULE_03 RULE_05 RULE_06
		state == adccal_pkg::adccal_st_run |=> cal_channel == $past(mode_word[2:0]))
		else $error("calibration channel not the selected one");

	// Sticky event flags; a set beats a clearing read
	a_zero_flag: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_02
		zero_done |=> irq_stat[0])
		else $error("zero-scale done flag not set");
	a_full_flag: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_04
		full_done |=> irq_stat[1])
		else $error("full-scale done flag not set");
	a_abort_flag: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_12
		cal_abort |=> irq_stat[2])
		else $error("abort flag not set");

	// Output coding and shared pins
	a_bipolar_code: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_09
		!mode_word[12] |=> code_out[DATA_W-1] == !$past(code_in[DATA_W-1]))
		else $error("bipolar coding wrong");
	a_unipolar_code: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_10
		mode_word[12] && code_in[DATA_W-1] |=> code_out == '0)
		else $error("unipolar negative not clamped");
	a_pin_drive: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_11 RULE_13
		mode_word[11] |=> shared_input3_port_pin_oe && shared_input3_port_pin_o == $past(mode_word[10]))
		else $error("shared pin not driven to port bit");
	a_pin4_drive: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_11 RULE_13
		mode_word[11] |=> shared_input4_port_pin_oe && shared_input4_port_pin_o == $past(mode_word[9]))
		else $error("second shared pin not driven to port bit");
	a_pin_release: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_11
		!mode_word[11] |=> !shared_input3_port_pin_oe && !shared_input4_port_pin_oe &&
		!shared_input3_port_pin_o && !shared_input4_port_pin_o)
		else $error("shared pins driven while port disabled");

endmodule

// *** tb/adccal_host_model.sv ***
// Host model: classic Wishbone master standing in for the microcontroller.
// Assumes the bench calls access() and a slave that answers with ack.
`timescale 1ns/1ns
module adccal_host_model (
	// Clock
	input wire logic clk_sys,
	// Wishbone master
	output logic wb_cyc_o,
	output logic wb_stb_o,
	output logic wb_we_o,
	output logic [7:0] wb_adr_o,
	output logic [3:0] wb_sel_o,
	output logic [31:0] wb_dat_o,
	input wire logic [31:0] wb_dat_i,
	input wire logic wb_ack_i
);
	initial begin
		wb_cyc_o = 1'b0;
		wb_stb_o = 1'b0;
		wb_we_o = 1'b0;
		wb_adr_o = 8'h00;
		wb_sel_o = 4'hf;
		wb_dat_o = 32'h0;
	end
	// Held until ack is seen at an edge; only the bench timeout ends a hang
	task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_sys);
		wb_cyc_o <= 1'b1;
		wb_stb_o <= 1'b1;
		wb_we_o <= w;
		wb_adr_o <= a;
		wb_dat_o <= d;
		@(posedge clk_sys);
		while (wb_ack_i !== 1'b1) @(posedge clk_sys);
		q = wb_dat_i;
		wb_cyc_o <= 1'b0;
		wb_stb_o <= 1'b0;
		wb_we_o <= 1'b0;
		// Released lines show no stale value
		wb_adr_o <= ~a;
		wb_dat_o <= ~d;
	endtask
endmodule

// *** tb/adc_calibration_mode_control_test.sv ***
// Self-checking bench: calibrations, abort, output coding, port pins.
// Assumes the host model as bus master and a shortened calibration count.
`timescale 1ns/1ns
`include "adccal_defines.svh"
module adc_calibration_mode_control_test;
	logic clk_sys, sys_rst, cyc, stb, we, ack, ready_n, irq, c_short, c_full, o3, oe3, o4, oe4;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [2:0] chan;
	logic [31:0] dw, dr, rd, v, off_e, gain_e, mask;
	logic [31:0] seed = 32'h00014ace;
	bit off_k, gain_k;
	int failures = 0, cmp_count = 0, cycles = 0;

	adccal_mode_ctrl #(.CAL_CYCLES(16)) DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
		.ready_n(ready_n), .irq(irq), .cal_channel(chan), .cal_internal_short(c_short), .cal_internal_full(c_full),
		.shared_input3_port_pin_o(o3), .shared_input3_port_pin_oe(oe3), .shared_input4_port_pin_o(o4),
		.shared_input4_port_pin_oe(oe4));
	adccal_host_model host (.clk_sys(clk_sys), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr),
		.wb_sel_o(sel), .wb_dat_o(dw), .wb_dat_i(dr), .wb_ack_i(ack));

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Offset binary, or straight binary with negatives clamped and span doubled
	function automatic logic [31:0] coded(input logic pol, input logic [23:0] s);
		if (!pol)
			return {8'h00, ~s[23], s[22:0]};
		return s[23] ? 32'h0 : {8'h00, s[22:0], 1'b0};
	endfunction
	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		host.access(1'b1, a, d, rd);
	endtask
	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		host.access(1'b0, a, 32'h0, rd);
		chk(nm, e, rd);
	endtask
	task automatic cal(input logic [2:0] m, input logic ab);
		int n;
		logic [2:0] ch;
		logic [31:0] stat;
		v = xs() & 32'h00ffffff;
		ch = v[2:0];
		stat = {29'h0, ab, m[0], ~m[0]};
		wr(`ADCCAL_OFS_CAL_INPUT, v);
		wr(`ADCCAL_OFS_MODE, {16'h0000, m, 10'h000, ch});
		@(negedge clk_sys);
		chk("ready_n", 32'h1, ready_n);
		chk("channel", ch, chan);
		chk("short", m == 3'h4, c_short);
		chk("full", m == 3'h5, c_full);
		rdc("status", `ADCCAL_OFS_STATUS, 32'h3);
		n = 0;
		while (ready_n !== 1'b0 && n < 40) begin
			@(negedge clk_sys);
			n++;
		end
		chk("ready_n", 32'h0, ready_n);
		if (m[0]) begin
			gain_e = v;
			gain_k = 1;
		end else begin
			off_e = v;
			off_k = 1;
		end
		rdc("mode", `ADCCAL_OFS_MODE, {29'h0, ch});
		rdc("status", `ADCCAL_OFS_STATUS, 32'h0);
		if (off_k) rdc("offset", `ADCCAL_OFS_OFFSET_CAL, off_e);
		if (gain_k) rdc("gain", `ADCCAL_OFS_GAIN_CAL, gain_e);
		chk("irq", |(stat & mask), irq);
		rdc("irq_stat", `ADCCAL_OFS_IRQ_STAT, stat);
		@(negedge clk_sys);
		chk("irq", 32'h0, irq);
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures++;
			give_verdict();
		end
	end
	initial begin
		sys_rst = 1'b1;
		mask = 32'h3;
		repeat (3) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rdc("mode", `ADCCAL_OFS_MODE, 32'h00000174);
		wr(8'h3c, xs());
		rdc("unmapped", 8'h3c, 32'h0);
		wr(`ADCCAL_OFS_IRQ_MASK, mask);
		for (int i = 0; i < 8; i++) cal(i[2:0] | 3'h4, 1'b0);
		// Masked abort: zero-scale run cut short by a full-scale request
		mask = 32'h0;
		wr(`ADCCAL_OFS_IRQ_MASK, mask);
		wr(`ADCCAL_OFS_MODE, 32'h00008004);
		cal(3'h5, 1'b1);
		for (int p = 0; p < 2; p++) begin
			wr(`ADCCAL_OFS_MODE, {19'h0, p[0], 12'h0});
			for (int k = 0; k < 8; k++) begin
				v = (k == 0) ? 32'h0 : (k == 1) ? 32'h800000 : (k == 2) ? 32'h7fffff : xs() & 32'hffffff;
				wr(`ADCCAL_OFS_CODE_IN, v);
				rdc("code", `ADCCAL_OFS_CODE_OUT, coded(p[0], v[23:0]));
			end
		end
		for (int k = 0; k < 8; k++) begin
			wr(`ADCCAL_OFS_MODE, {20'h0, k[2:0], 9'h0});
			@(negedge clk_sys);
			chk("pin3", {k[2], k[2] & k[1]}, {oe3, o3});
			chk("pin4", {k[2], k[2] & k[0]}, {oe4, o4});
		end
		give_verdict();
	end
endmodule
